// >>> rtl/rx_path_pkg.sv
// Purpose: constants for the receive path
// Assumes: 100 MHz pclk, 32-bit APB
// Notes:   shared by the receive path and its bench
package rx_path_pkg;
  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [7:0] MODE_OFS  = 8'h00;
  localparam logic [7:0] CRS_OFS   = 8'h04;
  localparam logic [7:0] RCA_OFS   = 8'h08;
  localparam logic [7:0] RCB_OFS   = 8'h0c;
  localparam int MODE_RUN_BIT      = 0;
  localparam int MODE_LOOP_BIT     = 1;
  localparam int MODE_CMT_BIT      = 2;
  localparam int MODE_NRZI_BIT     = 7;
  localparam int RCB_SD_BIT        = 0;
  localparam int RCB_OVR_BIT       = 5;
  localparam logic [7:0] MODE_RST  = 8'h00;
  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int PCLK_NS           = 10;
  localparam int BYTE_NS           = 1600;
  localparam int BYTE_CYC          = BYTE_NS / PCLK_NS;
  localparam logic [7:0] BYTE_LAST = 8'(BYTE_CYC - 1);
  // ---------------------------------------------------------------
  // framing patterns and symbol codes
  // ---------------------------------------------------------------
  localparam logic [9:0] PAT_JK    = 10'h311;
  localparam logic [9:0] PAT_HH    = 10'h084;
  localparam logic [9:0] PAT_HQ    = 10'h080;
  localparam logic [3:0] PAIR_LAST = 4'h9;
  localparam logic [3:0] SYM_LAST  = 4'h4;
  localparam logic [4:0] C_IDLE    = 5'h1f;
  localparam logic [4:0] C_HALT    = 5'h04;
  localparam logic [4:0] C_QUIET   = 5'h00;
  localparam logic [4:0] C_J       = 5'h18;
  localparam logic [4:0] C_K       = 5'h11;
  localparam logic [4:0] C_T       = 5'h0d;
  localparam logic [4:0] C_R       = 5'h07;
  localparam logic [4:0] C_S       = 5'h19;
  localparam logic [3:0] D_IDLE    = 4'ha;
  localparam logic [3:0] D_HALT    = 4'h1;
  localparam logic [3:0] D_JK      = 4'hd;
  localparam logic [3:0] D_T       = 4'h5;
  localparam logic [3:0] D_R       = 4'h6;
  localparam logic [3:0] D_S       = 4'h7;
  localparam logic [3:0] D_VIOL    = 4'h2;
  localparam logic [3:0] D_INVAL   = 4'h3;
  localparam logic [3:0] D_IDLE_LS = 4'hb;
  // ---------------------------------------------------------------
  // line state detector thresholds in symbol pairs, recenter period in bytes, buffer separation
  // ---------------------------------------------------------------
  localparam logic [4:0] N_IDLE    = 5'h02;
  localparam logic [4:0] N_SUPER   = 5'h09;
  localparam logic [4:0] N_HLS     = 5'h08;
  localparam logic [4:0] N_NOISE   = 5'h10;
  localparam logic [1:0] RECENTER_LAST = 2'h3;
  localparam logic [2:0] EB_SEP    = 3'h4;

  typedef enum logic [3:0] {
    LS_ACTIVE = 4'h0, LS_IDLE   = 4'h1, LS_SUPER  = 4'h2,
    LS_NOSIG  = 4'h3, LS_MASTER = 4'h4, LS_HALT   = 4'h5,
    LS_QUIET  = 4'h6, LS_NOISE  = 4'h7, LS_UNKNOWN = 4'h8
  } line_state_t;

  typedef enum logic [2:0] {
    PC_IDLE = 3'h0, PC_HQ = 3'h1, PC_HH = 3'h2, PC_QQ = 3'h3,
    PC_JK   = 3'h4, PC_FRAME = 3'h5, PC_NOISE = 3'h6
  } pair_class_t;
endpackage : rx_path_pkg

// >>> rtl/fddi_rx_path.sv
// Purpose: receive path: decode, framing, line states, elasticity buffer
// Assumes: link pins sampled by pclk; local byte clock is a divider enable
// Notes:   registers reached over APB, no wait states
//
// Functional notes
// - nrzi_bypass clear converts NRZI to NRZ
// - frame alignment on J-K pattern
// - also align on Halt-Halt, Halt-Quiet in connection_management
// - decode sixteen data codes to data nibbles
// - control codes and violations decode as listed
// - 0011 marks invalid or stuff byte
// - 1011 marks idle in idle state or stuff
// - two symbols plus line state form output word
// - J-K enters Active, frame symbols keep it
// - Idle after two idle pairs
// - Super Idle after nine idle pairs
// - signal detect low gives no-signal state
// - Master after eight Halt-Quiet pairs
// - Halt after eight Halt-Halt pairs
// - Quiet after eight Quiet pairs
// - Noise after sixteen noise pairs
// - one inconsistent pair gives Unknown
// - line state readable in two registers
// - buffer trouble sets buffer_overrun flag
// - skew absorbed by idle pair insert/delete
// - written on receive side, read on byte clock
// - recenter on J-K and every four bytes idle/invalid
// - output word: parity, control, two symbols
// - run clear forces no signal, Unknown
`timescale 1ns/100ps
`default_nettype none
module fddi_rx_path (
  // apb
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic             pslverr,
  output logic [31:0]      prdata,
  // serial link pins
  input  wire logic        recovered_line_clock,
  input  wire logic        rx_serial_data,
  input  wire logic        signal_detect_input,
  // internal loopback from the transmitter
  input  wire logic        loop_clock,
  input  wire logic        loop_data,
  // byte-wide output to the configuration switch
  output logic [9:0]       indicate_word,
  output logic             indicate_strobe,
  output logic [3:0]       line_state
);
  import rx_path_pkg::*;

  // ---------------------------------------------------------------
  // functions
  // ---------------------------------------------------------------
  // {control, nibble} of one 5-bit code
  function automatic logic [4:0] dec5(input logic [4:0] c);
    logic [4:0] r;
    r = {1'b1, D_VIOL};
    unique case (c)
      5'h1e: r = 5'h00;  5'h09: r = 5'h01;  5'h14: r = 5'h02;
      5'h15: r = 5'h03;  5'h0a: r = 5'h04;  5'h0b: r = 5'h05;
      5'h0e: r = 5'h06;  5'h0f: r = 5'h07;  5'h12: r = 5'h08;
      5'h13: r = 5'h09;  5'h16: r = 5'h0a;  5'h17: r = 5'h0b;
      5'h1a: r = 5'h0c;  5'h1b: r = 5'h0d;  5'h1c: r = 5'h0e;
      5'h1d: r = 5'h0f;
      C_IDLE:   r = {1'b1, D_IDLE};
      C_HALT:   r = {1'b1, D_HALT};
      C_J, C_K: r = {1'b1, D_JK};
      C_T:      r = {1'b1, D_T};
      C_R:      r = {1'b1, D_R};
      C_S:      r = {1'b1, D_S};
      default:  r = {1'b1, D_VIOL};                      // quiet and violations
    endcase
    return r;
  endfunction : dec5

  function automatic logic is_frame_sym(input logic [4:0] c);
    logic [4:0] d;
    d = dec5(c);
    return !d[4] || c == C_T || c == C_R || c == C_S;
  endfunction : is_frame_sym

  function automatic logic odd_par(input logic [8:0] d);
    return ~^d;
  endfunction : odd_par

  // ---------------------------------------------------------------
  // synchronisers for link pins
  // ---------------------------------------------------------------
  logic [4:0] meta_q, sync_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= {recovered_line_clock, rx_serial_data, signal_detect_input,
                 loop_clock, loop_data};
      sync_q <= meta_q;
    end
  end

  logic [7:0] mode_q;
  logic       lclk_q;
  logic       lclk_now, ldat_now, sd_now;
  assign lclk_now = mode_q[MODE_LOOP_BIT] ? sync_q[1] : sync_q[4];
  assign ldat_now = mode_q[MODE_LOOP_BIT] ? sync_q[0] : sync_q[3];
  assign sd_now   = sync_q[2] & mode_q[MODE_RUN_BIT];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) lclk_q <= 1'b0;
    else          lclk_q <= lclk_now;
  end
  logic bit_stb;
  assign bit_stb = lclk_now & ~lclk_q;

  // ---------------------------------------------------------------
  // nrzi decoder and shift register
  // ---------------------------------------------------------------
  logic       prev_q, nrz;
  logic [9:0] sr_q, sr_d;
  assign nrz  = mode_q[MODE_NRZI_BIT] ? ldat_now : (ldat_now ^ prev_q);
  assign sr_d = {sr_q[8:0], nrz};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_q <= 1'b0;
      sr_q   <= '0;
    end else if (bit_stb) begin
      prev_q <= ldat_now;
      sr_q   <= sr_d;
    end
  end

  // ---------------------------------------------------------------
  // framing
  // ---------------------------------------------------------------
  logic [3:0] bcnt_q;
  logic       hit_jk, hit_cmt, frame_hit, pair_done;
  assign hit_jk    = sr_d == PAT_JK;
  assign hit_cmt   = mode_q[MODE_CMT_BIT] && bcnt_q != SYM_LAST &&
                     (sr_d == PAT_HH || sr_d == PAT_HQ);
  assign frame_hit = hit_jk | hit_cmt;
  assign pair_done = bit_stb & (frame_hit | bcnt_q == PAIR_LAST);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)          bcnt_q <= '0;
    else if (pair_done)    bcnt_q <= '0;
    else if (bit_stb)      bcnt_q <= bcnt_q + 4'h1;
  end

  // ---------------------------------------------------------------
  // first decoder level: latch aligned pair
  // ---------------------------------------------------------------
  logic [9:0] pair_q;
  logic       pair_v_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pair_q   <= '0;
      pair_v_q <= 1'b0;
    end else begin
      pair_v_q <= pair_done;
      if (pair_done) pair_q <= sr_d;
    end
  end

  logic [4:0] d_hi, d_lo;
  assign d_hi = dec5(pair_q[9:5]);
  assign d_lo = dec5(pair_q[4:0]);

  pair_class_t pcls;
  always_comb begin
    if (pair_q == {C_IDLE, C_IDLE})             pcls = PC_IDLE;
    else if (pair_q == PAT_HQ)                  pcls = PC_HQ;
    else if (pair_q == PAT_HH)                  pcls = PC_HH;
    else if (pair_q == {C_QUIET, C_QUIET})      pcls = PC_QQ;
    else if (pair_q == PAT_JK)                  pcls = PC_JK;
    else if (is_frame_sym(pair_q[9:5]) && is_frame_sym(pair_q[4:0]))
                                                pcls = PC_FRAME;
    else                                        pcls = PC_NOISE;
  end

  // ---------------------------------------------------------------
  // line state detector
  // ---------------------------------------------------------------
  line_state_t ls_q;
  pair_class_t last_q;
  logic [4:0]  run_q;
  logic [4:0]  run_n;
  assign run_n = (pcls == last_q && run_q != N_NOISE) ? run_q + 5'h01 :
                 (pcls == last_q) ? run_q : 5'h01;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_q <= PC_NOISE;
      run_q  <= '0;
    end else if (pair_v_q) begin
      last_q <= pcls;
      run_q  <= run_n;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) ls_q <= LS_UNKNOWN;
    else if (!mode_q[MODE_RUN_BIT]) ls_q <= LS_UNKNOWN;
    else if (!sd_now) ls_q <= LS_NOSIG;
    else if (ls_q == LS_NOSIG) ls_q <= LS_UNKNOWN;
    else if (pair_v_q) begin
      unique case (pcls)
        PC_JK: ls_q <= LS_ACTIVE;
        PC_FRAME:
          if (ls_q != LS_ACTIVE) ls_q <= LS_UNKNOWN;
        PC_IDLE:
          if (run_n >= N_SUPER)     ls_q <= LS_SUPER;
          else if (run_n >= N_IDLE) ls_q <= LS_IDLE;
          else if (ls_q != LS_IDLE && ls_q != LS_SUPER && ls_q != LS_ACTIVE)
            ls_q <= LS_UNKNOWN;
        PC_HQ:
          if (run_n >= N_HLS) ls_q <= LS_MASTER;
          else if (ls_q != LS_MASTER) ls_q <= LS_UNKNOWN;
        PC_HH:
          if (run_n >= N_HLS) ls_q <= LS_HALT;
          else if (ls_q != LS_HALT) ls_q <= LS_UNKNOWN;
        PC_QQ:
          if (run_n >= N_HLS) ls_q <= LS_QUIET;
          else if (ls_q != LS_QUIET) ls_q <= LS_UNKNOWN;
        PC_NOISE:
          if (run_n >= N_NOISE) ls_q <= LS_NOISE;
          else if (ls_q != LS_NOISE) ls_q <= LS_UNKNOWN;
      endcase
    end
  end
  assign line_state = ls_q;

  logic ls_invalid;
  assign ls_invalid = ls_q inside {LS_IDLE, LS_SUPER, LS_MASTER, LS_HALT,
                                   LS_QUIET, LS_NOISE, LS_NOSIG};

  // ---------------------------------------------------------------
  // second decoder level: pair plus line state
  // ---------------------------------------------------------------
  logic [8:0] entry;
  always_comb begin
    entry = {d_hi[4] | d_lo[4], d_hi[3:0], d_lo[3:0]};
    if (ls_q == LS_NOISE || ls_q == LS_NOSIG || ls_q == LS_UNKNOWN &&
        pcls == PC_NOISE)
      entry = {1'b1, D_INVAL, D_INVAL};
    else if (pcls == PC_IDLE && (ls_q == LS_IDLE || ls_q == LS_SUPER))
      entry = {1'b1, D_IDLE_LS, D_IDLE_LS};
  end

  // ---------------------------------------------------------------
  // local byte clock divider
  // ---------------------------------------------------------------
  logic [7:0] div_q;
  logic       byte_en;
  assign byte_en = div_q == BYTE_LAST;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)     div_q <= '0;
    else if (byte_en) div_q <= '0;
    else              div_q <= div_q + 8'h01;
  end

  // ---------------------------------------------------------------
  // elasticity buffer
  // ---------------------------------------------------------------
  logic [8:0] eb_mem [8];
  logic [2:0] wp_q, rp_q;
  logic [1:0] rc_cnt_q;
  logic       jk_seen_q, eb_empty, eb_full, ovr_evt, recenter;
  assign eb_empty = wp_q == rp_q;
  assign eb_full  = wp_q + 3'h1 == rp_q;
  // collisions mean the skew can no longer be absorbed
  assign ovr_evt  = (pair_v_q & eb_full) | (byte_en & eb_empty & ~recenter);
  assign recenter = byte_en & (jk_seen_q |
                    (ls_invalid && rc_cnt_q == RECENTER_LAST));

  // unwritten entries read back as stuff after an early recenter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) eb_mem <= '{default: {1'b1, D_INVAL, D_INVAL}};
    else if (pair_v_q) eb_mem[wp_q] <= entry;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) wp_q <= '0;
    else if (pair_v_q && !eb_full) wp_q <= wp_q + 3'h1;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rp_q     <= '0;
      rc_cnt_q <= '0;
    end else if (byte_en) begin
      rc_cnt_q <= rc_cnt_q + 2'h1;
      // idle pairs are dropped or repeated by the jump
      if (recenter)       rp_q <= wp_q - EB_SEP;
      else if (!eb_empty) rp_q <= rp_q + 3'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) jk_seen_q <= 1'b0;
    else if (pair_v_q && pcls == PC_JK) jk_seen_q <= 1'b1;
    else if (byte_en) jk_seen_q <= 1'b0;
  end

  // ---------------------------------------------------------------
  // output word
  // ---------------------------------------------------------------
  logic [8:0] rd_word;
  always_comb begin
    if (!eb_empty && !recenter) rd_word = eb_mem[rp_q];
    else if (ls_q == LS_IDLE || ls_q == LS_SUPER)
      rd_word = {1'b1, D_IDLE_LS, D_IDLE_LS};
    else
      rd_word = {1'b1, D_INVAL, D_INVAL};
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      indicate_word   <= '0;
      indicate_strobe <= 1'b0;
    end else begin
      indicate_strobe <= byte_en;
      if (byte_en) indicate_word <= {odd_par(rd_word), rd_word};
    end
  end

  // ---------------------------------------------------------------
  // apb registers
  // ---------------------------------------------------------------
  logic [8:0] rca_q;
  logic       ovr_q;
  logic       wr_acc, rd_setup, hit;
  assign wr_acc   = psel & penable & pwrite;
  assign rd_setup = psel & ~penable & ~pwrite;
  assign hit      = paddr inside {MODE_OFS, CRS_OFS, RCA_OFS, RCB_OFS};
  assign pready   = 1'b1;
  assign pslverr  = psel & penable & ~hit;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) mode_q <= MODE_RST;
    else if (wr_acc && paddr == MODE_OFS) mode_q <= pwdata[7:0];
  end

  // sticky, write one to clear; a new event beats the clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rca_q <= '0;
      ovr_q <= 1'b0;
    end else begin
      rca_q <= (rca_q & ~((wr_acc && paddr == RCA_OFS) ? pwdata[8:0] : 9'h000))
               | (9'h001 << ls_q);
      if (ovr_evt) ovr_q <= 1'b1;
      else if (wr_acc && paddr == RCB_OFS && pwdata[RCB_OVR_BIT]) ovr_q <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) prdata <= '0;
    else if (rd_setup) begin
      unique case (paddr)
        MODE_OFS: prdata <= {24'h000000, mode_q};
        CRS_OFS:  prdata <= {28'h0000000, ls_q};
        RCA_OFS:  prdata <= {23'h000000, rca_q};
        RCB_OFS:  prdata <= 32'(({ovr_q, 5'h00} | {5'h00, sd_now}));
        default:  prdata <= '0;
      endcase
    end
  end
endmodule : fddi_rx_path
`default_nettype wire

// >>> test/fddi_rx_path_monitor.sv
// Purpose: port-level checker for the receive path
// Assumes: one pclk domain, presetn async active low
// Notes:   mode bits tracked from observed apb writes
`timescale 1ns/100ps
`default_nettype none
module fddi_rx_path_monitor (
  // apb
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [31:0] prdata,
  // link and output
  input wire logic        signal_detect_input,
  input wire logic [9:0]  indicate_word,
  input wire logic        indicate_strobe,
  input wire logic [3:0]  line_state
);
  import rx_path_pkg::*;
  logic [7:0] mode_q;
  logic [1:0] off_q;
  logic [7:0] gap_q;
  logic       seen_q;
  logic       acc;
  logic       mapped;
  assign acc    = psel && penable;
  assign mapped = paddr inside {MODE_OFS, CRS_OFS, RCA_OFS, RCB_OFS};
  // ------------------------------------------------------------
  // helper state
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) mode_q <= MODE_RST;
    else if (acc && pwrite && paddr == MODE_OFS) mode_q <= pwdata[7:0];
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) off_q <= 2'h0;
    else if (mode_q[MODE_RUN_BIT]) off_q <= 2'h0;
    else if (off_q != 2'h3) off_q <= off_q + 2'h1;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gap_q  <= 8'h00;
      seen_q <= 1'b0;
    end else if (indicate_strobe) begin
      gap_q  <= 8'h00;
      seen_q <= 1'b1;
    end else begin
      gap_q  <= gap_q + 8'h01;
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  AST_PREADY: assert property (acc |-> pready)
    else $error("pready low in access phase");
  AST_SLVERR: assert property (acc && !mapped |-> pslverr)
    else $error("no slave error on unmapped address");
  AST_RD_UNMAPPED: assert property (acc && !pwrite && !mapped |-> prdata == 32'h0)
    else $error("unmapped read not zero");
  AST_MODE_RB: assert property (acc && !pwrite && paddr == MODE_OFS |-> prdata[7:0] == mode_q)
    else $error("mode readback differs from last write");
  AST_PARITY: assert property (indicate_strobe |-> ^indicate_word == 1'b1)
    else $error("output word parity not odd");
  AST_GAP: assert property (indicate_strobe && seen_q |-> gap_q == BYTE_LAST)
    else $error("strobe spacing wrong");
  AST_WORD_STANDS: assert property (!indicate_strobe |-> $stable(indicate_word))
    else $error("output word changed without strobe");
  AST_RUN_OFF: assert property (off_q == 2'h3 |-> line_state == LS_UNKNOWN)
    else $error("run clear but state not unknown");
  AST_NOSIG: assert property
    ((mode_q[MODE_RUN_BIT] && !signal_detect_input) [*6] |-> line_state == LS_NOSIG)
    else $error("signal lost but state not no-signal");
  COV_ACTIVE: cover property (line_state == LS_ACTIVE);
  COV_NOISE:  cover property (line_state == LS_NOISE);
  COV_SLVERR: cover property (acc && pslverr);
endmodule : fddi_rx_path_monitor
bind fddi_rx_path fddi_rx_path_monitor u_mon (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata),
  .signal_detect_input(signal_detect_input), .indicate_word(indicate_word),
  .indicate_strobe(indicate_strobe), .line_state(line_state)
);
`default_nettype wire

// >>> test/link_source.sv
// Purpose: serial link source in place of the clock recovery device
// Assumes: 160 ns bit period, symbols sent msb first
// Notes:   clock stands still between bursts, data then inverted
`timescale 1ns/100ps
`default_nettype none
module link_source (
  // serial link
  output logic clk,
  output logic dat
);
  logic nrzi;
  logic lvl;
  initial begin
    clk  = 1'b0;
    dat  = 1'b0;
    nrzi = 1'b0;
    lvl  = 1'b0;
  end
  task automatic send_bit(input logic b);
    lvl = nrzi ? (lvl ^ b) : b;
    dat = lvl;
    #80 clk = 1'b1;
    #80 clk = 1'b0;
  endtask : send_bit
  task automatic send_pairs(input logic [4:0] a, input logic [4:0] b, input int n);
    repeat (n) begin
      for (int i = 4; i >= 0; i--) send_bit(a[i]);
      for (int i = 4; i >= 0; i--) send_bit(b[i]);
    end
    // line released: show the inverse, not the last bit
    dat = ~lvl;
  endtask : send_pairs
endmodule : link_source
`default_nettype wire

// >>> test/fddi_rx_path_tb_top.sv
// Purpose: self-checking bench for the receive path
// Assumes: apb master tasks, link_source as far side
// Notes:   loopback inputs tied low
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin fail_count++; \
  $display("[FAIL] %s expected %h seen %h", n, e, g); end end
module fddi_rx_path_tb_top;
  import rx_path_pkg::*;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic        pready;
  logic        pslverr;
  logic [31:0] prdata;
  logic        sd = 1'b1;
  logic        lclk;
  logic        ldat;
  logic [9:0]  word;
  logic        strobe;
  logic [3:0]  ls;
  logic        cap = 1'b0;
  logic [9:0]  words[$];
  int          fail_count = 0;
  int          total_checks = 0;
  int          cyc = 0;
  logic [4:0]  sa[4] = '{C_HALT, C_HALT, C_QUIET, 5'h01};
  logic [4:0]  sb[4] = '{C_QUIET, C_HALT, C_QUIET, 5'h01};
  int          cnt[4] = '{9, 9, 9, 17};
  logic [3:0]  ex[4] = '{LS_MASTER, LS_HALT, LS_QUIET, LS_NOISE};
  always #5 pclk = ~pclk;
  link_source u_link (.clk(lclk), .dat(ldat));
  fddi_rx_path dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata),
    .recovered_line_clock(lclk), .rx_serial_data(ldat), .signal_detect_input(sd),
    .loop_clock(1'b0), .loop_data(1'b0), .indicate_word(word),
    .indicate_strobe(strobe), .line_state(ls)
  );
  always @(posedge pclk) if (cap && strobe === 1'b1) words.push_back(word);
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 40000) begin
      fail_count++;
      complete_run();
    end
  end
  // ------------------------------------------------------------
  // apb tasks
  // ------------------------------------------------------------
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] rd);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    xfer(1'b1, a, d, x);
  endtask : wr
  task automatic chk(input string n, input logic [7:0] a, input logic [31:0] m,
                     input logic [31:0] e);
    logic [31:0] d;
    repeat (10) @(posedge pclk);
    xfer(1'b0, a, 32'h0, d);
    `CHK(n, e, d & m)
  endtask : chk
  function automatic logic has(input logic [8:0] v);
    foreach (words[i]) if (words[i][8:0] === v) return 1'b1;
    return 1'b0;
  endfunction : has
  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : complete_run
  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    chk("mode reset", MODE_OFS, 32'hff, 32'h0);
    chk("state reset", CRS_OFS, 32'hf, {28'h0, LS_UNKNOWN});
    chk("unmapped", 8'h10, 32'hffffffff, 32'h0);
    wr(MODE_OFS, 32'h81);
    u_link.send_pairs(C_IDLE, C_IDLE, 3);
    chk("idle", CRS_OFS, 32'hf, {28'h0, LS_IDLE});
    u_link.send_pairs(C_IDLE, C_IDLE, 7);
    chk("super idle", CRS_OFS, 32'hf, {28'h0, LS_SUPER});
    cap <= 1'b1;
    u_link.send_pairs(C_J, C_K, 1);
    u_link.send_pairs(5'h1e, 5'h1d, 1);
    u_link.send_pairs(C_T, C_S, 1);
    chk("active", CRS_OFS, 32'hf, {28'h0, LS_ACTIVE});
    `CHK("state pin", LS_ACTIVE, ls)
    u_link.send_pairs(C_IDLE, C_IDLE, 8);
    cap <= 1'b0;
    `CHK("data word", 1'b1, has(9'h00f))
    `CHK("ctrl word", 1'b1, has(9'h157))
    for (int k = 0; k < 4; k++) begin
      u_link.send_pairs(sa[k], sb[k], cnt[k]);
      chk("pair state", CRS_OFS, 32'hf, {28'h0, ex[k]});
    end
    chk("states seen", RCA_OFS, 32'h1ff, 32'h1f7);
    wr(RCA_OFS, 32'h1ff);
    chk("seen cleared", RCA_OFS, 32'h1ff, 32'h080);
    sd <= 1'b0;
    chk("no signal", CRS_OFS, 32'hf, {28'h0, LS_NOSIG});
    chk("sd bit", RCB_OFS, 32'h1, 32'h0);
    wr(MODE_OFS, 32'h80);
    chk("run off", CRS_OFS, 32'hf, {28'h0, LS_UNKNOWN});
    sd <= 1'b1;
    wr(MODE_OFS, 32'h01);
    u_link.nrzi = 1'b1;
    u_link.send_pairs(C_IDLE, C_IDLE, 10);
    chk("nrzi idle", CRS_OFS, 32'hf, {28'h0, LS_SUPER});
    chk("overrun seen", RCB_OFS, 32'h20, 32'h20);
    wr(RCB_OFS, 32'h20);
    u_link.send_pairs(C_J, C_K, 1);
    u_link.send_pairs(5'h1e, 5'h1d, 1);
    chk("nrzi active", CRS_OFS, 32'hf, {28'h0, LS_ACTIVE});
    chk("no overrun", RCB_OFS, 32'h20, 32'h0);
    u_link.nrzi = 1'b0;
    wr(MODE_OFS, 32'h85);
    repeat (3) u_link.send_bit(1'b1);
    u_link.send_pairs(C_HALT, C_QUIET, 1);
    chk("off boundary", CRS_OFS, 32'hf, {28'h0, LS_UNKNOWN});
    u_link.send_pairs(C_HALT, C_QUIET, 8);
    chk("cmt framing", CRS_OFS, 32'hf, {28'h0, LS_MASTER});
    complete_run();
  end
endmodule : fddi_rx_path_tb_top
`default_nettype wire
